// >>> hw/scsf_pkg.sv
// package: constants, carriers and state of the smart-card status flag block
package scsf_pkg;
  localparam int          CLK_MHZ       = 50;
  localparam int          BIT_RATE_BPS  = 9600;
  localparam int          ETU_NS        = 1000000000 / BIT_RATE_BPS;
  localparam int          HALF_ETU_CYC  = (ETU_NS * CLK_MHZ) / 2000;
  localparam int          DIV_W         = 16;
  // timer targets in half-etu steps
  localparam logic [4:0]  GUARD_SLOW_H  = 5'h05;
  localparam logic [4:0]  GUARD_FAST_H  = 5'h02;
  localparam logic [4:0]  RETRY_H       = 5'h04;
  localparam logic [4:0]  ERR_AT_H      = 5'h15;
  localparam logic [4:0]  ERR_END_H     = 5'h17;
  // register byte addresses
  localparam logic [3:0]  ADR_STATUS    = 4'h0;
  localparam logic [3:0]  ADR_CONTROL   = 4'h4;
  localparam logic [3:0]  ADR_IRQ_STS   = 4'h8;
  localparam logic [3:0]  ADR_IRQ_MASK  = 4'hc;
  // serial_status bit positions
  localparam int          B_TXEMPTY     = 7;
  localparam int          B_RXFULL      = 6;
  localparam int          B_OVERRUN     = 5;
  localparam int          B_BIT4        = 4;
  localparam int          B_PARITY      = 3;
  localparam int          B_TXEND       = 2;
  localparam int          B_MP_IN       = 1;
  localparam int          B_MP_OUT      = 0;
  localparam logic [7:0]  STATUS_RST    = 8'h84;
  localparam logic [7:0]  W0C_MASK      = 8'hf8;
  // control bit positions
  localparam int          C_TXEN        = 0;
  localparam int          C_CARD        = 1;
  localparam int          C_TSEL        = 2;
  // irq bit positions
  localparam int          I_ERRSIG      = 0;
  localparam int          I_TXEND       = 1;
  localparam int          I_RXERR       = 2;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_GUARD = 2'b01,
    TX_RETRY = 2'b11
  } scsf_tx_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } scsf_wb_req_t;

  typedef struct packed {
    logic txempty_set;
    logic rxfull_set;
    logic overrun_set;
    logic parity_set;
    logic fer_set;
    logic char_done;
    logic err_sample;
    logic rx_start;
    logic rx_bad;
    logic mp_in;
  } scsf_evt_t;

  typedef struct packed {
    logic             ack;
    logic [31:0]      rdat;
    logic [7:0]       sts;
    logic [7:0]       arm;
    logic [2:0]       ctl;
    logic [2:0]       irqs;
    logic [2:0]       irqm;
    scsf_tx_t         tx;
    logic [DIV_W-1:0] tdiv;
    logic [4:0]       thalf;
    logic             resend;
    logic [DIV_W-1:0] rdiv;
    logic [4:0]       rhalf;
    logic             rbusy;
    logic             rbad;
    logic             oe;
  } scsf_state_t;
endpackage

// >>> hw/scsf_flags.sv
// smart-card status flags: error-signal flag, transmit-end timing, wishbone regs
//
// The Wishbone slave port and the register addresses were left to the implementer.
`timescale 1ns/1ns
// Contract
// - bit 4 is error-signal flag in card mode
// - low sample in error window sets flag
// - clear error flag by read one, write zero
// - reset or standby: error 0, end flag 1
// - clearing transmit enable keeps error flag
// - no framing error in card mode
// - end flag clears on empty-flag clear
// - end flag sets while tx disabled, no error
// - timing select 0: transmit_end_flag 2.5 etu
// - timing select 1: transmit_end_flag 1.0 etu
// - written ones to flags are ignored
// - all timing counted in etu
// - parity-bad receiver drives line low
// - resend at least 2 etu after error
// - card behaviour only with card mode on
module scsf_flags #(
  parameter logic [15:0] HALF_ETU_CYCLES = 16'(scsf_pkg::HALF_ETU_CYC)
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire scsf_pkg::scsf_wb_req_t wb_i,
  output logic [31:0]                 wb_dat_o,
  output logic                        wb_ack_o,
  input  wire logic                   standby_i,
  input  wire scsf_pkg::scsf_evt_t    evt_i,
  input  wire logic                   line_i,
  output logic                        line_o,
  output logic                        line_oe_o,
  output logic                        resend_o,
  output logic                        tx_enable_o,
  output logic                        card_mode_o,
  output logic                        timing_sel_o,
  output logic                        mp_out_o,
  output logic                        irq_o
);
  import scsf_pkg::*;

  scsf_state_t q;
  scsf_state_t next_q;
  logic        stb;
  logic        wr;
  logic        rd_cap;
  logic        errsig_set;
  logic        tx_start;
  logic        guard_done;
  logic        ttick;
  logic        rtick;
  logic [7:0]  setv;
  logic [7:0]  sclr;
  logic [2:0]  iev;
  logic [4:0]  gtarget;

  function automatic logic div_tick(input logic [DIV_W-1:0] cnt);
    return cnt == HALF_ETU_CYCLES - 16'h0001;
  endfunction

  function automatic logic [DIV_W-1:0] div_next(input logic [DIV_W-1:0] cnt);
    return div_tick(cnt) ? '0 : DIV_W'(cnt + 16'h0001);
  endfunction

  function automatic logic [31:0] rd_mux(input logic [3:0] adr, input scsf_state_t s);
    if (adr == ADR_STATUS) begin
      return {24'h00_0000, s.sts};
    end else if (adr == ADR_CONTROL) begin
      return {29'h0000_0000, s.ctl};
    end else if (adr == ADR_IRQ_STS) begin
      return {29'h0000_0000, s.irqs};
    end else if (adr == ADR_IRQ_MASK) begin
      return {29'h0000_0000, s.irqm};
    end else begin
      return 32'h0000_0000;
    end
  endfunction

  always_comb begin
    next_q     = q;
    next_q.resend = 1'b0;
    stb        = wb_i.cyc & wb_i.stb;
    next_q.ack = stb & ~q.ack;
    wr         = stb & q.ack & wb_i.we;
    rd_cap     = stb & ~q.ack & ~wb_i.we;
    tx_start   = 1'b0;
    guard_done = 1'b0;
    setv       = 8'h00;
    sclr       = 8'h00;
    iev        = 3'h0;
    // read data is latched with the ack so it stays put while ack is high
    if (rd_cap) begin
      next_q.rdat = rd_mux(wb_i.adr, q);
    end
    // only bits seen as one on this read may be cleared later
    if (rd_cap && wb_i.adr == ADR_STATUS) begin
      next_q.arm = q.sts;
    end

    errsig_set = q.ctl[C_CARD] & evt_i.err_sample & ~line_i;
    setv[B_TXEMPTY] = evt_i.txempty_set;
    setv[B_RXFULL]  = evt_i.rxfull_set;
    setv[B_OVERRUN] = evt_i.overrun_set;
    setv[B_PARITY]  = evt_i.parity_set;
    // bit 4 is the error-signal flag in card mode, framing error otherwise
    setv[B_BIT4] = q.ctl[C_CARD] ? errsig_set : evt_i.fer_set;

    if (wr && wb_i.adr == ADR_STATUS && wb_i.sel[0]) begin
      // a written one clears nothing
      sclr = q.arm & ~wb_i.dat[7:0] & W0C_MASK;
      next_q.arm = 8'h00;
      next_q.sts[B_MP_OUT] = wb_i.dat[B_MP_OUT];
    end
    // set wins over a clear in the same cycle
    next_q.sts[7:3] = (q.sts[7:3] & ~sclr[7:3]) | setv[7:3];
    next_q.sts[B_MP_IN] = evt_i.mp_in;

    // tx guard and retry timers count half-etu ticks from their own start
    ttick = div_tick(q.tdiv);
    gtarget = q.ctl[C_TSEL] ? GUARD_FAST_H : GUARD_SLOW_H;
    if (q.tx != TX_IDLE) begin
      next_q.tdiv = div_next(q.tdiv);
      if (ttick) begin
        next_q.thalf = q.thalf + 5'h01;
      end
    end
    case (q.tx)
      TX_GUARD: begin
        if (ttick && q.thalf + 5'h01 == gtarget) begin
          guard_done = 1'b1;
          next_q.tx = TX_IDLE;
        end
      end
      TX_RETRY: begin
        if (ttick && q.thalf + 5'h01 == RETRY_H) begin
          next_q.resend = 1'b1;
          next_q.tx = TX_IDLE;
        end
      end
      default: begin
      end
    endcase
    if (errsig_set) begin
      tx_start = 1'b1;
      next_q.tx = TX_RETRY;
    end else if (evt_i.char_done && q.ctl[C_CARD]) begin
      tx_start = 1'b1;
      next_q.tx = TX_GUARD;
    end
    if (tx_start) begin
      next_q.tdiv = '0;
      next_q.thalf = 5'h00;
    end

    // transmit end: cleared with the buffer-empty flag, sets below take priority
    if (sclr[B_TXEMPTY]) begin
      next_q.sts[B_TXEND] = 1'b0;
    end
    if (guard_done && q.sts[B_TXEMPTY] && !q.sts[B_BIT4]) begin
      next_q.sts[B_TXEND] = 1'b1;
    end
    if (!q.ctl[C_CARD] && evt_i.char_done && q.sts[B_TXEMPTY]) begin
      next_q.sts[B_TXEND] = 1'b1;
    end
    if (!q.ctl[C_TXEN] && !q.sts[B_BIT4]) begin
      next_q.sts[B_TXEND] = 1'b1;
    end

    // receive side error signal, window timed from the start edge
    rtick = div_tick(q.rdiv);
    if (q.rbusy) begin
      next_q.rdiv = div_next(q.rdiv);
      if (rtick) begin
        next_q.rhalf = q.rhalf + 5'h01;
        if (q.rhalf + 5'h01 == ERR_END_H) begin
          next_q.rbusy = 1'b0;
        end
      end
    end
    if (evt_i.rx_bad) begin
      next_q.rbad = 1'b1;
    end
    if (evt_i.rx_start) begin
      next_q.rbusy = 1'b1;
      next_q.rbad = 1'b0;
      next_q.rdiv = '0;
      next_q.rhalf = 5'h00;
    end
    next_q.oe = next_q.rbusy & next_q.rbad & q.ctl[C_CARD] &
                (next_q.rhalf >= ERR_AT_H) & (next_q.rhalf < ERR_END_H);

    if (wr && wb_i.adr == ADR_CONTROL && wb_i.sel[0]) begin
      // dropping transmit enable leaves bit 4 alone
      next_q.ctl = wb_i.dat[2:0];
    end
    if (wr && wb_i.adr == ADR_IRQ_MASK && wb_i.sel[0]) begin
      next_q.irqm = wb_i.dat[2:0];
    end
    iev[I_ERRSIG] = errsig_set;
    iev[I_TXEND]  = ~q.sts[B_TXEND] & next_q.sts[B_TXEND];
    iev[I_RXERR] = next_q.oe & ~q.oe;
    next_q.irqs = q.irqs | iev;
    if (wr && wb_i.adr == ADR_IRQ_STS && wb_i.sel[0]) begin
      next_q.irqs = (q.irqs & ~wb_i.dat[2:0]) | iev;
    end

    // standby acts on status bits 7:2 and the timers like a chip reset
    if (standby_i) begin
      next_q.sts[7:2] = STATUS_RST[7:2];
      next_q.arm = 8'h00;
      next_q.tx = TX_IDLE;
      next_q.rbusy = 1'b0;
      next_q.oe = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.sts <= STATUS_RST;
    end else begin
      q <= next_q;
    end
  end

  assign wb_dat_o     = q.rdat;
  assign wb_ack_o     = q.ack;
  assign line_o       = 1'b0;
  assign line_oe_o    = q.oe;
  assign resend_o     = q.resend;
  assign tx_enable_o  = q.ctl[C_TXEN];
  assign card_mode_o  = q.ctl[C_CARD];
  assign timing_sel_o = q.ctl[C_TSEL];
  assign mp_out_o     = q.sts[B_MP_OUT];
  assign irq_o        = |(q.irqs & q.irqm);

  // cycles since the last tx timer start, read only by the checks below
  logic [19:0] el;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      el <= 20'h0_0000;
    end else if (tx_start) begin
      el <= 20'h0_0001;
    end else if (el != 20'hf_ffff) begin
      el <= el + 20'h0_0001;
    end
  end

  logic st_wr;
  assign st_wr = wr && wb_i.adr == ADR_STATUS && wb_i.sel[0];

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_errsig_set;
    q.ctl[C_CARD] && evt_i.err_sample && !line_i && !standby_i |=> q.sts[B_BIT4];
  endproperty
  a_errsig_set: assert property (p_errsig_set) else $error("error flag not set");

  // reset must not disable its own check, so the default disable is overridden
  property p_reset;
    disable iff (1'b0) rst_i |=> q.sts[B_TXEND] && !q.sts[B_BIT4] && !line_oe_o;
  endproperty
  a_reset: assert property (@(posedge clk_i) p_reset) else $error("bad reset flags");

  property p_no_fer;
    q.ctl[C_CARD] && !q.sts[B_BIT4] && !evt_i.err_sample |=> !q.sts[B_BIT4];
  endproperty
  a_no_fer: assert property (p_no_fer) else $error("framing error flagged");

  property p_txen_keep;
    $fell(q.ctl[C_TXEN]) && !$past(st_wr) && !$past(standby_i) && !$past(errsig_set)
      |-> $stable(q.sts[B_BIT4]);
  endproperty
  a_txen_keep: assert property (p_txen_keep) else $error("error flag changed");

  property p_armed_clear;
    $fell(q.sts[B_BIT4]) && !$past(standby_i) |-> $past(st_wr) && $past(q.arm[B_BIT4]);
  endproperty
  a_armed_clear: assert property (p_armed_clear) else $error("unarmed clear");

  property p_one_ignored;
    st_wr && wb_i.dat[B_BIT4] && !standby_i && q.sts[B_BIT4] |=> q.sts[B_BIT4];
  endproperty
  a_one_ignored: assert property (p_one_ignored) else $error("one cleared flag");

  property p_txend_idle;
    !q.ctl[C_TXEN] && !q.sts[B_BIT4] |=> q.sts[B_TXEND];
  endproperty
  a_txend_idle: assert property (p_txend_idle) else $error("end flag not set");

  property p_txend_clear;
    $fell(q.sts[B_TXEND]) |-> $past(st_wr) && $past(q.arm[B_TXEMPTY]) &&
      !$past(wb_i.dat[B_TXEMPTY]);
  endproperty
  a_txend_clear: assert property (p_txend_clear) else $error("end flag cleared");

  property p_guard_time;
    guard_done |-> el == 20'(int'(gtarget) * int'(HALF_ETU_CYCLES));
  endproperty
  a_guard_time: assert property (p_guard_time) else $error("guard time wrong");

  property p_retry_time;
    $rose(resend_o) |-> $past(el) == 20'(int'(RETRY_H) * int'(HALF_ETU_CYCLES));
  endproperty
  a_retry_time: assert property (p_retry_time) else $error("retry wait wrong");

  property p_err_drive;
    line_oe_o |-> q.rhalf >= ERR_AT_H && q.rhalf < ERR_END_H && q.ctl[C_CARD];
  endproperty
  a_err_drive: assert property (p_err_drive) else $error("drive outside window");

  property p_line_low;
    line_oe_o |-> !line_o;
  endproperty
  a_line_low: assert property (p_line_low) else $error("error signal not low");

  property p_set_wins;
    st_wr && evt_i.txempty_set && !standby_i |=> q.sts[B_TXEMPTY];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("set lost to clear");

  property p_standby;
    standby_i |=> q.sts[B_TXEND] && !q.sts[B_BIT4] && !line_oe_o;
  endproperty
  a_standby: assert property (p_standby) else $error("bad standby flags");

  property p_plain_oe;
    !q.ctl[C_CARD] |=> !line_oe_o;
  endproperty
  a_plain_oe: assert property (p_plain_oe) else $error("drive in plain mode");

  property p_fer_plain;
    !q.ctl[C_CARD] && evt_i.fer_set && !standby_i |=> q.sts[B_BIT4];
  endproperty
  a_fer_plain: assert property (p_fer_plain) else $error("framing error lost");

  // only the armed write or standby may take the error flag down
  property p_sticky;
    q.sts[B_BIT4] && !st_wr && !standby_i |=> q.sts[B_BIT4];
  endproperty
  a_sticky: assert property (p_sticky) else $error("error flag dropped");

  c_errsig: cover property (errsig_set);
  c_guard: cover property (guard_done && q.sts[B_TXEMPTY]);
  c_resend: cover property (resend_o);
  c_drive: cover property ($rose(line_oe_o));
endmodule // scsf_flags

// >>> testbench/scsf_card.sv
// IC card model on the pulled-up data line: answers a bad character with an error signal
`timescale 1ns/1ns
module scsf_card #(
  parameter int H = 4
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic frame_i,
  input  wire logic reject_i,
  output logic      drive_o
);
  int cnt;
  // clock-cycle count from the start bit edge; -1 while idle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= -1;
    end else if (frame_i && reject_i) begin
      cnt <= 0;
    end else if (cnt >= 0 && cnt < 23 * H) begin
      cnt <= cnt + 1;
    end else begin
      cnt <= -1;
    end
  end
  // low for one etu from 10.5 etu; released otherwise so the pull-up wins
  assign drive_o = (cnt >= 21 * H) && (cnt < 23 * H);
endmodule // scsf_card

// >>> testbench/testbench.sv
// testbench: wishbone tasks, card model, status flag scenarios
`timescale 1ns/1ns
module testbench;
  import scsf_pkg::*;
  localparam int H = 4;
  localparam logic [9:0] EV_BAD = 10'h002, EV_RXS = 10'h004, EV_SMP = 10'h008;
  localparam logic [9:0] EV_DONE = 10'h010, EV_FER = 10'h020, EV_TXE = 10'h200;
  logic         clk_i, rst_i, standby_i, frame, reject, drive, line;
  logic         wb_ack_o, line_o, line_oe_o, resend_o, irq_o, mp_out_o;
  logic         txen_o, cmode_o, tsel_o;
  logic [31:0]  wb_dat_o, rd;
  scsf_wb_req_t wb_i;
  scsf_evt_t    ev;
  int           error_cnt, n_tests, cyc_cnt, n, st, m;

  // open drain: released line reads high through the pull-up
  assign line = !(line_oe_o || drive);
  scsf_flags #(.HALF_ETU_CYCLES(16'(H))) dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .standby_i(standby_i), .evt_i(ev), .line_i(line),
    .line_o(line_o), .line_oe_o(line_oe_o), .resend_o(resend_o), .tx_enable_o(txen_o),
    .card_mode_o(cmode_o), .timing_sel_o(tsel_o), .mp_out_o(mp_out_o), .irq_o(irq_o));
  scsf_card #(.H(H)) card (
    .clk_i(clk_i), .rst_i(rst_i), .frame_i(frame), .reject_i(reject), .drive_o(drive));

  initial begin
    clk_i = 0;
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 5000) begin
      error_cnt++;
      final_report();
    end
  end

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wb(logic w, logic [3:0] a, logic [7:0] d);
    int t;
    t = 0;
    @(posedge clk_i);
    wb_i <= '{1'b1, 1'b1, w, a, 4'hf, {24'h0, d}};
    do begin
      @(posedge clk_i);
      t++;
    end while (wb_ack_o !== 1'b1 && t < 50);
    chk("ack", wb_ack_o, 1'b1);
    rd = wb_dat_o;
    wb_i <= '0;
  endtask
  task automatic rdchk(logic [3:0] a, int exp, string nm);
    wb(1'b0, a, 8'h00);
    chk(nm, rd, 32'(exp));
  endtask
  task automatic irqchk(logic exp);
    @(posedge clk_i);
    chk("irq", irq_o, exp);
  endtask
  task automatic pulse(logic [9:0] b);
    scsf_evt_t e;
    e = scsf_evt_t'(b);
    e.mp_in = ev.mp_in;
    @(posedge clk_i);
    ev <= e;
    @(posedge clk_i);
    ev <= '{mp_in: ev.mp_in, default: 1'b0};
  endtask
  // counts edges until the watched output goes high, bounded
  task automatic wait_hi(ref logic s);
    n = 0;
    while (s !== 1'b1 && n < 120) begin
      @(posedge clk_i);
      n++;
    end
  endtask
  task automatic err_hit(logic rej);
    reject <= rej;
    frame <= 1'b1;
    @(posedge clk_i);
    frame <= 1'b0;
    repeat (22 * H - 1) @(posedge clk_i);
    pulse(EV_SMP);
    wait_hi(resend_o);
    if (rej) m = m | 'h10;
    chk("resend_gap", n >= 4 * H - 1 && n <= 4 * H + 2, rej);
    rdchk(ADR_STATUS, m, "status_err");
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    rst_i = 1;
    standby_i = 0;
    wb_i = '0;
    ev = '0;
    frame = 0;
    reject = 0;
    {error_cnt, n_tests, cyc_cnt} = '0;
    st = $urandom(32'h681b_5b15);
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    st = $urandom & 1;
    ev <= '{mp_in: st[0], default: 1'b0};
    m = 'h84 | (st << 1);
    rdchk(ADR_STATUS, m, "status_rst");
    rdchk(ADR_CONTROL, 0, "control_rst");
    wb(1'b1, 4'h2, 8'($urandom));
    rdchk(4'h2, 0, "unmapped");
    $display("test reset done");
    // error signal, interrupt, transmit disable, standby
    wb(1'b1, ADR_CONTROL, 8'h03);
    err_hit(1'b0);
    err_hit(1'b1);
    wb(1'b1, ADR_IRQ_MASK, 8'h01);
    irqchk(1'b1);
    wb(1'b1, ADR_IRQ_MASK, 8'h00);
    irqchk(1'b0);
    wb(1'b1, ADR_IRQ_MASK, 8'h01);
    wb(1'b1, ADR_IRQ_STS, 8'h01);
    irqchk(1'b0);
    wb(1'b1, ADR_CONTROL, 8'h02);
    rdchk(ADR_STATUS, m, "status_tx_off");
    standby_i <= 1;
    @(posedge clk_i);
    standby_i <= 0;
    m = 'h84 | (st << 1);
    rdchk(ADR_STATUS, m, "status_standby");
    $display("test error signal done");
    // framing events are ignored in card mode only; clear needs a fresh read
    pulse(EV_FER);
    rdchk(ADR_STATUS, m, "fer_card");
    wb(1'b1, ADR_CONTROL, 8'h01);
    pulse(EV_FER);
    m = m | 'h10;
    rdchk(ADR_STATUS, m, "fer_plain");
    wb(1'b1, ADR_STATUS, 8'hff);
    wb(1'b1, ADR_STATUS, 8'hef);
    m = m | 'h01;
    rdchk(ADR_STATUS, m, "no_arm");
    chk("mp_out", mp_out_o, 1'b1);
    wb(1'b1, ADR_STATUS, 8'hee);
    m = m & 'hee;
    rdchk(ADR_STATUS, m, "cleared");
    $display("test clear done");
    // transmit end after the guard time of each timing select
    for (int s = 0; s < 2; s++) begin
      wb(1'b1, ADR_CONTROL, 8'(3 + 4 * s));
      rdchk(ADR_STATUS, m, "arm");
      chk("ctl_pins", {tsel_o, cmode_o, txen_o}, 32'(3 + 4 * s));
      wb(1'b1, ADR_STATUS, 8'h7e);
      m = m & 'h7b;
      rdchk(ADR_STATUS, m, "tx_busy");
      wb(1'b1, ADR_IRQ_STS, 8'h07);
      wb(1'b1, ADR_IRQ_MASK, 8'h02);
      pulse(EV_TXE);
      pulse(EV_DONE);
      wait_hi(irq_o);
      m = m | 'h84;
      chk("guard", n >= (5 - 3 * s) * H - 1 && n <= (5 - 3 * s) * H + 2, 1);
      rdchk(ADR_STATUS, m, "tx_done");
    end
    $display("test guard done");
    // parity-bad reception answers with a one-etu error signal
    pulse(EV_RXS);
    pulse(EV_BAD);
    wait_hi(line_oe_o);
    chk("err_start", n + 2 >= 21 * H - 1 && n + 2 <= 21 * H + 2, 1);
    chk("line_o", line_o, 1'b0);
    n = 0;
    while (line_oe_o === 1'b1 && n < 40) begin
      @(posedge clk_i);
      n++;
    end
    chk("err_width", n, 2 * H);
    // disabling transmission with no error forces the end flag
    rdchk(ADR_STATUS, m, "arm");
    wb(1'b1, ADR_STATUS, 8'h7e);
    wb(1'b1, ADR_CONTROL, 8'h02);
    m = m & 'h7f;
    rdchk(ADR_STATUS, m, "tx_forced");
    $display("test receive done");
    final_report();
  end
endmodule // testbench
